// [hw/lts_params.svh]
// timing counts, width limits and reset values for the transmit serializer
// assumes inclusion by bare name from the package and the serializer module
`ifndef LTS_PARAMS_SVH
`define LTS_PARAMS_SVH
`define LTS_MAX_WIDTH 10
`define LTS_MIN_FACTOR 3
`define LTS_RESET_FACTOR 4'ha
`define LTS_PHASE_STEPS 8
`define LTS_PHASE_DEG 45
`define LTS_BUF_DEPTH 2
`endif

// [hw/lts_pkg.sv]
// types shared by the transmit serializer
// assumes lts_params.svh is on the include path
`include "lts_params.svh"
package lts_pkg;
    typedef enum logic [1:0] {LTS_SERIAL, LTS_DDR, LTS_SDR} lts_mode_e;
    typedef struct packed {
        lts_mode_e mode;
        logic clockOut;
        logic [3:0] factor;
        logic [3:0] clkDiv;
        logic [2:0] phase;
    } lts_cfg_s;
    typedef logic [`LTS_MAX_WIDTH-1:0] lts_word_t;
endpackage : lts_pkg

// [hw/lts_serializer.sv]
// parallel to serial transmitter with clock-forward and bypass modes
// assumes clk_sys is the serial bit clock; config is static while running
// Function
// - a parallel word of up to ten bits is captured into load registers and shifted out.
// - the most significant bit of each word goes out first, the rest in descending order.
// - the serialization factor is static and may be any value from 3 to 10.
// - the load strobe is made with the bit clock and its period follows the factor.
// - the channel can carry a forwarded clock instead of data.
// - the forwarded clock runs at data rate or divided by 1, 2, 4, 6, 8 or 10.
// - the forwarded clock phase is set statically in 45 degree steps.
// - bypass gives double rate (factor 2) or single rate (factor 1).
// - bypass goes through the shift register and then the output register, in double rate and in single rate alike.
// - in bypass the fabric gives one bit per cycle in single rate and two every other cycle in double rate.
`timescale 1ns/1ps
`include "lts_params.svh"
module lts_serializer #(
    parameter int WIDTH = `LTS_MAX_WIDTH
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire lts_pkg::lts_cfg_s cfg,
    input wire lts_pkg::lts_word_t inData,
    input wire logic inValid,
    output logic inReady,
    output logic serialOut,
    output logic loadStrobe,
    output logic underrun
);
    import lts_pkg::*;
    // refuse a word width that the shift path cannot serve
    if (WIDTH < `LTS_MIN_FACTOR || WIDTH > `LTS_MAX_WIDTH) begin : g_bad_width
        $error("WIDTH out of range");
    end

    // two-entry buffer between fabric and load register
    lts_word_t bufMem_q [`LTS_BUF_DEPTH];
    logic bufWr_q, bufRd_q;
    logic [1:0] bufCnt_q;
    wire bufEmpty = (bufCnt_q == 2'h0);
    wire bufFull = (bufCnt_q == 2'h2);
    wire pushEn = inValid && !bufFull;
    wire popEn;
    wire lts_word_t bufHead = bufMem_q[bufRd_q];

    // load strobe divider
    logic [3:0] bitCnt_q;
    wire [3:0] effFactor = (cfg.mode == LTS_DDR) ? 4'h2 : (cfg.mode == LTS_SDR) ? 4'h1 :
                           (cfg.factor < 4'h3) ? 4'h3 : cfg.factor;
    wire lastBit = (bitCnt_q == effFactor - 4'h1);
    assign popEn = lastBit && !bufEmpty && !cfg.clockOut;

    // shift register; loaded word left-aligned at bit WIDTH-1
    lts_word_t shift_q;
    wire [3:0] padBits = 4'(WIDTH) - effFactor;
    wire lts_word_t loadWord = bufEmpty ? '0 : (bufHead << padBits);
    wire lts_word_t shiftNext = lastBit ? loadWord : {shift_q[WIDTH-2:0], 1'b0};

    // forwarded clock: toggle every clkDiv bit clocks (0 acts as 1), phase sets start offset
    logic [3:0] divCnt_q;
    logic fwdClk_q;
    wire [3:0] halfPer = (cfg.clkDiv == 4'h0) ? 4'h1 : cfg.clkDiv;
    wire divWrap = (divCnt_q >= halfPer - 4'h1);
    // offset in bit clocks is phase eighths of a full period of 2*halfPer
    wire [6:0] phaseProd = {4'h0, cfg.phase} * {3'h0, halfPer};
    wire [4:0] phaseOff = phaseProd[6:2];
    // offsets of half a period or more start in the high half
    wire fwdStart = (phaseOff >= {1'b0, halfPer});
    wire [4:0] phaseRem = phaseOff - {1'b0, halfPer};
    wire [3:0] phaseStart = fwdStart ? phaseRem[3:0] : phaseOff[3:0];

    wire outBit = cfg.clockOut ? fwdClk_q : shift_q[WIDTH-1];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bufWr_q <= 1'b0;
            bufRd_q <= 1'b0;
            bufCnt_q <= 2'h0;
        end else begin
            if (pushEn) bufWr_q <= ~bufWr_q;
            if (popEn) bufRd_q <= ~bufRd_q;
            bufCnt_q <= bufCnt_q + {1'b0, pushEn} - {1'b0, popEn};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (pushEn) bufMem_q[bufWr_q] <= inData;
    end

    // bit counter and shift register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bitCnt_q <= 4'h0;
            shift_q <= '0;
        end else begin
            bitCnt_q <= lastBit ? 4'h0 : bitCnt_q + 4'h1;
            shift_q <= shiftNext;
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            serialOut <= 1'b0;
            loadStrobe <= 1'b0;
            underrun <= 1'b0;
            inReady <= 1'b0;
        end else begin
            serialOut <= outBit;
            loadStrobe <= lastBit;
            underrun <= lastBit && bufEmpty && !cfg.clockOut;
            inReady <= !(bufFull || (bufCnt_q == 2'h1 && pushEn && !popEn));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            divCnt_q <= phaseStart;
            fwdClk_q <= fwdStart;
        end else if (!cfg.clockOut) begin
            divCnt_q <= phaseStart;
            fwdClk_q <= fwdStart;
        end else if (divWrap) begin
            divCnt_q <= 4'h0;
            fwdClk_q <= ~fwdClk_q;
        end else begin
            divCnt_q <= divCnt_q + 4'h1;
        end
    end

    // serial factor leaves at least two idle cycles between boundaries
    a_strobe_period: assert property (@(posedge clk_sys) disable iff (!resetn)
        (lastBit && cfg.mode == LTS_SERIAL) |=> !lastBit [*2])
        else $error("load strobe too close for factor");

    // msb of the loaded word is the first bit on the line
    a_msb_first: assert property (@(posedge clk_sys) disable iff (!resetn)
        (lastBit && !cfg.clockOut && cfg.mode == LTS_SERIAL) |=> ##1
        serialOut == $past(loadWord[WIDTH-1], 2))
        else $error("serial output not msb of loaded word");

    // buffer never holds more than two words
    a_buf_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
        bufCnt_q <= 2'h2)
        else $error("buffer overfilled");

    // forwarded clock toggles at each divider wrap
    a_clk_toggle: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cfg.clockOut && $stable(cfg.clockOut) && divWrap) |=> fwdClk_q != $past(fwdClk_q))
        else $error("forwarded clock failed to toggle");

    // clock mode puts the forwarded clock on the line
    a_clock_mode: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg.clockOut |=> serialOut == $past(fwdClk_q))
        else $error("clock mode output not the forwarded clock");

    // every word boundary shows as one strobe
    a_strobe_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
        lastBit |=> loadStrobe)
        else $error("load strobe missing at boundary");

    // no strobe away from a boundary
    a_strobe_only: assert property (@(posedge clk_sys) disable iff (!resetn)
        !lastBit |=> !loadStrobe)
        else $error("load strobe away from boundary");

    // a full buffer is never shown as ready
    a_ready_full: assert property (@(posedge clk_sys) disable iff (!resetn)
        bufFull |-> !inReady)
        else $error("ready shown while buffer full");

    // an empty buffer at a data boundary is flagged
    a_underrun_empty: assert property (@(posedge clk_sys) disable iff (!resetn)
        (lastBit && bufEmpty && !cfg.clockOut) |=> underrun)
        else $error("underrun not flagged");

    // a loaded word is never flagged as underrun
    a_underrun_false: assert property (@(posedge clk_sys) disable iff (!resetn)
        (lastBit && !bufEmpty) |=> !underrun)
        else $error("underrun flagged with data present");

    // bit counter stays inside the factor
    a_count_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
        bitCnt_q < effFactor)
        else $error("bit counter past factor");

    // single rate sends bit 0 of each word
    a_sdr_direct: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cfg.mode == LTS_SDR && !cfg.clockOut && !bufEmpty) |=> ##1
        serialOut == $past(bufHead[0], 2))
        else $error("single rate bit wrong");

    // double rate sends bit 1 then bit 0
    a_ddr_order: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cfg.mode == LTS_DDR && lastBit && !cfg.clockOut && !bufEmpty) |=> ##1
        serialOut == $past(bufHead[1], 2) ##1 serialOut == $past(bufHead[0], 3))
        else $error("double rate bit order wrong");

    // an accepted word without a pop grows the buffer by one
    a_push_taken: assert property (@(posedge clk_sys) disable iff (!resetn)
        (inValid && !bufFull && !popEn) |=> bufCnt_q == $past(bufCnt_q) + 2'h1)
        else $error("accepted word not stored");

    // divider count stays below the half period
    a_div_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg.clockOut |-> divCnt_q < halfPer)
        else $error("divider count past half period");

    // clock mode never pops a word from the data buffer
    a_clock_nodata: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg.clockOut |-> !popEn)
        else $error("word popped in clock mode");

    // between boundaries the word moves up one bit per clock
    a_serial_shift: assert property (@(posedge clk_sys) disable iff (!resetn)
        (cfg.mode == LTS_SERIAL && !lastBit) |=> shift_q == ($past(shift_q) << 1))
        else $error("shift register did not shift");
endmodule : lts_serializer

// [sim/lts_rx_model.sv]
// far-side receiver model: counts ones and the spacing of the last two
// assumes one serial bit per clk_sys edge
`timescale 1ns/1ps
module lts_rx_model (
    input wire logic clk_sys,
    input wire logic clear,
    input wire logic serialIn,
    output logic [7:0] ones,
    output logic [7:0] gap
);
    logic [7:0] sinceQ;
    always_ff @(posedge clk_sys) begin
        sinceQ <= serialIn ? 8'h01 : sinceQ + 8'h01;
        ones <= clear ? 8'h00 : ones + 8'(serialIn);
        gap <= clear ? 8'h00 : (serialIn ? sinceQ : gap);
    end
endmodule : lts_rx_model

// [sim/lts_serializer_bench.sv]
// self-checking bench for the transmit serializer
// assumes lts_rx_model watches the serial line
`timescale 1ns/1ps
module lts_serializer_bench;
    import lts_pkg::*;
    logic clk_sys = 0, resetn = 0, inValid = 0, clear = 1, inReady, serialOut;
    lts_cfg_s cfg = '0;
    lts_word_t inData = '0;
    logic [7:0] ones, gap;
    logic loadStrobe, underrun;
    int fails = 0, checks = 0, cyc = 0;
    int strobes = 0, unders = 0;
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (++cyc == 20000) begin
        fails++;
        print_verdict();
    end
    lts_serializer i_lts_serializer (.clk_sys(clk_sys), .resetn(resetn), .cfg(cfg),
        .inData(inData), .inValid(inValid), .inReady(inReady), .serialOut(serialOut),
        .loadStrobe(loadStrobe), .underrun(underrun));
    // count strobe and underrun pulses while the model is not cleared
    always @(posedge clk_sys) begin
        strobes <= clear ? 0 : strobes + int'(loadStrobe);
        unders <= clear ? 0 : unders + int'(underrun);
    end
    lts_rx_model i_lts_rx_model (.clk_sys(clk_sys), .clear(clear), .serialIn(serialOut),
        .ones(ones), .gap(gap));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic start(input lts_cfg_s c);
        cfg = c;
        resetn = 0;
        clear = 1;
        repeat (10) @(negedge clk_sys);
        resetn = 1;
        @(negedge clk_sys);
        clear = 0;
    endtask : start
    // hold valid up across words so the stream stays back to back
    task automatic push(input lts_word_t w);
        inData = w;
        inValid = 1;
        while (inReady !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
    endtask : push
    task automatic run_pair(input lts_mode_e m, input int f);
        start('{m, 1'h0, 4'(f), 4'h1, 3'h0});
        push(lts_word_t'(1) << (f - 1));
        push(lts_word_t'(1));
        inValid = 0;
        repeat (40) @(negedge clk_sys);
        check(ones, 8'h02);
        check(gap, 8'(2 * f - 1));
        check(8'(strobes), 8'(42 / f));
        check(8'(unders), 8'(42 / f - 2));
        $display("test pair mode=%0d factor=%0d done", m, f);
    endtask : run_pair
    task automatic run_clock(input logic [2:0] ph);
        start('{LTS_SERIAL, 1'h1, 4'h4, 4'h2, ph});
        check(8'(serialOut), 8'(ph[2]));
        repeat (2) @(negedge clk_sys);
        check(8'(serialOut), 8'(!ph[2]));
        repeat (38) @(negedge clk_sys);
        check(ones, 8'h14);
        $display("test clock out phase=%0d done", ph);
    endtask : run_clock
    task automatic print_verdict();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial begin
        for (int f = 3; f <= 10; f++) run_pair(LTS_SERIAL, f);
        run_pair(LTS_DDR, 2);
        run_pair(LTS_SDR, 1);
        run_clock(3'h0);
        run_clock(3'h4);
        print_verdict();
    end
endmodule : lts_serializer_bench
